// *** src/oem_cfg_defines.svh ***
// Offsets, field positions, reset values and timing counts of the OEM configuration bank
`ifndef OEM_CFG_DEFINES_SVH
`define OEM_CFG_DEFINES_SVH

`define OEM_CFG_FIVE_ADDR     8'h1A
`define OEM_CFG_SIX_ADDR      8'h1B
`define OEM_CFG_FIVE_RESET    8'h00
`define OEM_CFG_SIX_RESET     8'h00
`define PW_BASE_LOW           8'h78
`define PW_BASE_HIGH          8'h7B
`define PW_BYTES              4

`define C5_LASER_SHUTDOWN_OUTPUT_OFF_BIT       7
`define C5_LUT_OFFSET_BIT     6
`define C5_RESULT_OFFSET_BIT  5
`define C5_FAULT_POL_BIT      4
`define C5_MULTIPART_BIT      3
`define C5_PW_LOC_BIT         2
`define C5_TIMEOUT_OFF_BIT    1
`define C6_A0_OFF_BIT         7
`define C6_LIN_MSB            6
`define C6_LIN_LSB            5
`define C6_DEBOUNCE_BIT       4

`define HARD_DELIMS           {12'hE00, 12'hC00, 12'hA00, 12'h800, 12'h600, 12'h400, 12'h200}
`define DEBOUNCE_TIME_MS      5
`define CLK_FREQ_KHZ          50000
`define DEBOUNCE_CNT_W        18

`endif

// *** src/oem_cfg_pkg.sv ***
// Types shared by the OEM configuration bank
package oem_cfg_pkg;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] data;
	} reg_req_t;

	typedef enum logic [1:0] {
		LIN_BY_TEMP    = 2'h0,
		LIN_PROG_DELIM = 2'h1,
		LIN_HARD_DELIM = 2'h2,
		LIN_RESERVED   = 2'h3
	} lin_mode_t;

	typedef logic [6:0][11:0] delim_set_t;

endpackage

// *** src/oem_config_control_bits.sv ***
// OEM configuration registers five and six and the control they steer
// Summary of operation
// RULE_01 - Shutdown bit 0 and pin in shutdown mode: transmit fault drives shutdown
// RULE_02 - Lookup offset bit 1 adds signed half-degree offset to averaging temperature
// RULE_03 - Result offset bit 1 adds signed six-bit offset to temperature result
// RULE_04 - Polarity bit 0 gives active-high transmit fault, 1 active-low
// RULE_05 - Multipart mode is on only while the multipart bit is 1
// RULE_06 - Password compared at 78h-7Bh or 7Bh-7Eh per location bit
// RULE_07 - Bus timeout active while timeout bit is 0
// RULE_08 - Base-space bit 1 makes every A0h access receive not-acknowledge
// RULE_09 - Two-bit field picks coefficients by temperature, programmable or fixed delimiters
// RULE_10 - Delimiter modes split the 12-bit receive power range into eight regions
// RULE_11 - Fixed delimiters free the delimiter memory as extra scratchpad
// RULE_12 - Debounce bit 1 rejects transmit-off glitches shorter than 5 ms
// RULE_13 - Host should enable debouncing only for a mechanical switch
// RULE_14 - Contents persist over warm resets; writes need a valid password
// RULE_15 - Undescribed bits are stored and read back unchanged
`include "oem_cfg_defines.svh"

module oem_config_control_bits
	import oem_cfg_pkg::*;
#(
	parameter logic [31:0] OEM_PASSWORD    = 32'h00000000,
	parameter int          DEBOUNCE_CYCLES = `DEBOUNCE_TIME_MS * `CLK_FREQ_KHZ
) (
	input  wire logic              clk,
	input  wire logic              resetn,
	input  wire reg_req_t          reg_req,
	output logic [7:0]             reg_rdata_q,
	input  wire logic              laser_shutdown_output_pin_mode,
	input  wire logic              fault_cond,
	output logic                   laser_shutdown_output_q,
	output logic                   transmit_fault_output_q,
	input  wire logic signed [10:0] temp_meas,
	input  wire logic signed [5:0]  temp_offset,
	output logic signed [10:0]     temp_result_q,
	output logic signed [10:0]     lut_temp_q,
	output logic                   multipart_en_q,
	output logic                   smbus_timeout_en_q,
	output logic                   a0_nack_q,
	output logic                   oem_mode_q,
	input  wire logic [11:0]       receive_power_result,
	input  wire delim_set_t        prog_delims,
	output lin_mode_t              lin_mode_q,
	output logic                   coef_by_temp_q,
	output logic [2:0]             rx_region_q,
	output logic                   scratch_extra_en_q,
	input  wire logic              transmit_off_input,
	output logic                   transmit_off_q
);

	// ==========================================================
	// Parameter checks
	if (DEBOUNCE_CYCLES < 1 || DEBOUNCE_CYCLES >= (1 << `DEBOUNCE_CNT_W)) begin : g_bad_debounce
		$error("DEBOUNCE_CYCLES out of range");
	end

	localparam logic [`DEBOUNCE_CNT_W-1:0] DEB_LAST = `DEBOUNCE_CNT_W'(DEBOUNCE_CYCLES - 1);

	function automatic logic signed [10:0] add_offset(input logic signed [10:0] meas,
			input logic signed [5:0] off, input logic en);
		logic signed [10:0] ext;
		ext = {{5{off[5]}}, off};
		add_offset = en ? 11'(meas + ext) : meas;
	endfunction

	// Delimiters ascend; region is how many of them the result has reached
	function automatic logic [2:0] region_of(input logic [11:0] val, input delim_set_t d);
		logic [2:0] n;
		n = 3'h0;
		for (int i = 0; i < 7; i++)
			if (val >= d[i])
				n = 3'(n + 3'h1);
		region_of = n;
	endfunction

	// ==========================================================
	// Register bank
	logic [7:0]       cfg5_q;
	logic [7:0]       cfg6_q;
	// Whole 78h-7Eh window kept, so moving the location needs a fresh password
	logic [6:0][7:0]  pw_q;

	wire        cfg_wr_ok = reg_req.wr && oem_mode_q;
	wire        wr_five   = cfg_wr_ok && reg_req.addr == `OEM_CFG_FIVE_ADDR;
	wire        wr_six    = cfg_wr_ok && reg_req.addr == `OEM_CFG_SIX_ADDR;
	wire [7:0]  pw_rel    = 8'(reg_req.addr - `PW_BASE_LOW);
	wire        wr_pw     = reg_req.wr && pw_rel < 8'(`PW_BASE_HIGH - `PW_BASE_LOW + `PW_BYTES);
	wire [31:0] pw_sel    = cfg5_q[`C5_PW_LOC_BIT] ? pw_q[6:3] : pw_q[3:0];
	wire [7:0]  rd_mux    = !oem_mode_q ? 8'h00 :
		reg_req.addr == `OEM_CFG_FIVE_ADDR ? cfg5_q :
		reg_req.addr == `OEM_CFG_SIX_ADDR ? cfg6_q : 8'h00;

	// Only power-on reset restores shipped values; warm resets never reach here
	always_ff @(posedge clk) begin
		if (!resetn) begin
			cfg5_q <= `OEM_CFG_FIVE_RESET;
			cfg6_q <= `OEM_CFG_SIX_RESET;
		end else begin
			if (wr_five)
				cfg5_q <= reg_req.data; // [RULE_14] [RULE_15]
			if (wr_six)
				cfg6_q <= reg_req.data; // [RULE_14] [RULE_15]
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			pw_q        <= '0;
			oem_mode_q  <= 1'b0;
			reg_rdata_q <= 8'h00;
		end else begin
			if (wr_pw)
				pw_q[pw_rel[2:0]] <= reg_req.data; // [RULE_06]
			oem_mode_q <= pw_sel == OEM_PASSWORD; // [RULE_06] [RULE_14]
			if (reg_req.rd)
				reg_rdata_q <= rd_mux;
		end
	end

	// ==========================================================
	// Fault, shutdown and bus control
	wire laser_shutdown_output_d  = laser_shutdown_output_pin_mode && !cfg5_q[`C5_LASER_SHUTDOWN_OUTPUT_OFF_BIT] && fault_cond;
	wire fault_d = fault_cond ^ cfg5_q[`C5_FAULT_POL_BIT];

	always_ff @(posedge clk) begin
		if (!resetn) begin
			laser_shutdown_output_q <= 1'b0;
			transmit_fault_output_q <= 1'b0;
			multipart_en_q          <= 1'b0;
			smbus_timeout_en_q      <= 1'b1;
			a0_nack_q               <= 1'b0;
		end else begin
			laser_shutdown_output_q <= laser_shutdown_output_d; // [RULE_01]
			transmit_fault_output_q <= fault_d; // [RULE_04]
			multipart_en_q          <= cfg5_q[`C5_MULTIPART_BIT]; // [RULE_05]
			smbus_timeout_en_q      <= !cfg5_q[`C5_TIMEOUT_OFF_BIT]; // [RULE_07]
			a0_nack_q               <= cfg6_q[`C6_A0_OFF_BIT]; // [RULE_08]
		end
	end

	// ==========================================================
	// Temperature offset
	always_ff @(posedge clk) begin
		if (!resetn) begin
			temp_result_q <= '0;
			lut_temp_q    <= '0;
		end else begin
			temp_result_q <= add_offset(temp_meas, temp_offset,
				cfg5_q[`C5_RESULT_OFFSET_BIT]); // [RULE_03]
			lut_temp_q    <= add_offset(temp_meas, temp_offset,
				cfg5_q[`C5_LUT_OFFSET_BIT]); // [RULE_02]
		end
	end

	// ==========================================================
	// Receive power linearization
	wire lin_mode_t lin_d   = lin_mode_t'(cfg6_q[`C6_LIN_MSB:`C6_LIN_LSB]);
	wire delim_set_t delims = (lin_d == LIN_HARD_DELIM) ? delim_set_t'(`HARD_DELIMS) : prog_delims;
	wire            delim_mode = lin_d == LIN_PROG_DELIM || lin_d == LIN_HARD_DELIM;

	// Reserved code selects no method: region held at zero
	always_ff @(posedge clk) begin
		if (!resetn) begin
			lin_mode_q         <= LIN_BY_TEMP;
			coef_by_temp_q     <= 1'b1;
			rx_region_q        <= 3'h0;
			scratch_extra_en_q <= 1'b0;
		end else begin
			lin_mode_q         <= lin_d; // [RULE_09]
			coef_by_temp_q     <= lin_d == LIN_BY_TEMP; // [RULE_09]
			rx_region_q        <= delim_mode ?
				region_of(receive_power_result, delims) : 3'h0; // [RULE_10]
			scratch_extra_en_q <= lin_d == LIN_HARD_DELIM; // [RULE_11]
		end
	end

	// ==========================================================
	// Transmit-off input debounce
	logic                      toff_meta_q;
	logic                      toff_sync_q;
	logic [`DEBOUNCE_CNT_W-1:0] deb_cnt_q;
	wire                       deb_en = cfg6_q[`C6_DEBOUNCE_BIT];

	// Mechanical switches only; debouncing delays a real disable by 5 ms
	always_ff @(posedge clk) begin
		if (!resetn) begin
			toff_meta_q    <= 1'b0;
			toff_sync_q    <= 1'b0;
			deb_cnt_q      <= '0;
			transmit_off_q <= 1'b0;
		end else begin
			toff_meta_q <= transmit_off_input;
			toff_sync_q <= toff_meta_q;
			if (!deb_en || toff_sync_q == transmit_off_q) begin
				deb_cnt_q <= '0;
				if (!deb_en)
					transmit_off_q <= toff_sync_q; // [RULE_12]
			end else if (deb_cnt_q == DEB_LAST) begin
				deb_cnt_q      <= '0;
				transmit_off_q <= toff_sync_q; // [RULE_12]
			end else begin
				deb_cnt_q <= `DEBOUNCE_CNT_W'(deb_cnt_q + 1'b1);
			end
		end
	end

	// ==========================================================
	// Checks
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	chk_laser_shutdown_output_gate: assert property (##1 laser_shutdown_output_q == // [RULE_01]
		$past(laser_shutdown_output_pin_mode && fault_cond && !cfg5_q[`C5_LASER_SHUTDOWN_OUTPUT_OFF_BIT]))
		else $error("shutdown output mismatch");
	chk_lut_offset: assert property (##1 lut_temp_q == ($past(cfg5_q[6]) ? // [RULE_02]
		11'($past(temp_meas) + {{5{$past(temp_offset[5])}}, $past(temp_offset)})
		: $past(temp_meas))) else $error("lookup temperature wrong");
	chk_result_offset: assert property (##1 !$past(cfg5_q[5]) |-> // [RULE_03]
		temp_result_q == $past(temp_meas)) else $error("result offset applied");
	chk_fault_polarity: assert property (##1 transmit_fault_output_q != // [RULE_04]
		($past(fault_cond) == $past(cfg5_q[4]))) else $error("fault polarity wrong");
	chk_multipart_follow: assert property (wr_five ##1 1'b1 |=> // [RULE_05]
		multipart_en_q == $past(cfg5_q[3])) else $error("multipart mode wrong");
	chk_pw_unlock: assert property (##1 oem_mode_q == ($past(cfg5_q[2]) ? // [RULE_06]
		$past(pw_q[6:3]) == OEM_PASSWORD : $past(pw_q[3:0]) == OEM_PASSWORD))
		else $error("password unlock wrong");
	chk_timeout_sense: assert property (##1 smbus_timeout_en_q != // [RULE_07]
		$past(cfg5_q[1])) else $error("timeout enable inverted");
	chk_a0_nack: assert property (##1 a0_nack_q == $past(cfg6_q[7])) // [RULE_08]
		else $error("base space nack wrong");
	chk_hard_scratch: assert property (##1 scratch_extra_en_q == // [RULE_11]
		($past(cfg6_q[6:5]) == 2'h2)) else $error("scratch enable wrong");
	chk_reserved_region: assert property (##1 !$past(delim_mode) |-> // [RULE_10]
		rx_region_q == 3'h0) else $error("region outside delimiter mode");
	chk_locked_write: assert property (reg_req.wr && !oem_mode_q |=> // [RULE_14]
		$stable(cfg5_q) && $stable(cfg6_q)) else $error("locked write took effect");
	chk_debounce_hold: assert property ($past(deb_en) && $changed(transmit_off_q) |-> // [RULE_12]
		$past(deb_cnt_q) == DEB_LAST) else $error("glitch passed debounce");

	cov_unlock_write: cover property (oem_mode_q && wr_six);
	cov_hard_region: cover property (lin_mode_q == LIN_HARD_DELIM && rx_region_q == 3'h7);
	cov_debounced_edge: cover property (deb_en && $changed(transmit_off_q));

endmodule

// *** tb/host_model.sv ***
// Host side model issuing byte accesses into the configuration space
module host_model
	import oem_cfg_pkg::*;
(
	input  wire logic       clk,
	input  wire logic [7:0] rdata,
	output reg_req_t        req
);
	timeunit 1ns;
	timeprecision 1ps;
	initial req = '0;
	// ====================
	// Bus cycles, launched on the falling edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
		@(negedge clk);
		req <= '0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, data: 8'h00};
		@(negedge clk);
		req <= '0;
		d = rdata;
	endtask
	// Lowest byte at base, highest at base plus three
	task automatic pw(input logic [7:0] base, input logic [31:0] p);
		for (int i = 0; i < 4; i++) begin
			wr(base + 8'(i), p[8*i+:8]);
		end
	endtask
endmodule

// *** tb/tb_oem_config_control_bits.sv ***
// Self-checking bench for the OEM configuration bank
`include "oem_cfg_defines.svh"
module tb_oem_config_control_bits
	import oem_cfg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] PW = 32'hA5C3_0F96; // Arbitrary value
	logic clk, resetn, pin_mode, fault, tx_off;
	logic signed [10:0] meas;
	logic signed [5:0] toff;
	logic [11:0] rxp;
	delim_set_t delims;
	reg_req_t req;
	logic [7:0] rdata;
	logic lso, tfo, mp, tmo, a0n, oem, cbt, sxe, txq;
	logic signed [10:0] tres, lut;
	lin_mode_t lin;
	logic [2:0] reg_n;
	int errors, check_count;
	oem_config_control_bits #(.OEM_PASSWORD(PW), .DEBOUNCE_CYCLES(20)) i_dut (.clk(clk),
		.resetn(resetn), .reg_req(req), .reg_rdata_q(rdata), .laser_shutdown_output_pin_mode(pin_mode),
		.fault_cond(fault), .laser_shutdown_output_q(lso), .transmit_fault_output_q(tfo),
		.temp_meas(meas), .temp_offset(toff), .temp_result_q(tres), .lut_temp_q(lut),
		.multipart_en_q(mp), .smbus_timeout_en_q(tmo), .a0_nack_q(a0n), .oem_mode_q(oem),
		.receive_power_result(rxp), .prog_delims(delims), .lin_mode_q(lin),
		.coef_by_temp_q(cbt), .rx_region_q(reg_n), .scratch_extra_en_q(sxe),
		.transmit_off_input(tx_off), .transmit_off_q(txq));
	host_model i_host (.clk(clk), .rdata(rdata), .req(req));
	// ====================
	// Helpers
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %s exp %0h got %0h", n, e, g);
		end
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] v;
		i_host.rd(a, v);
		chk("readback", 16'(e), 16'(v));
	endtask
	// Let the write land and the registered outputs follow
	task automatic wrs(input logic [7:0] a, input logic [7:0] d);
		i_host.wr(a, d);
		repeat (3) @(negedge clk);
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// ====================
	// Scenarios
	task automatic t_lock();
		wrs(`OEM_CFG_SIX_ADDR, 8'h80);
		chk("locked nack", 16'h0, 16'(a0n));
		rdc(8'h30, 8'h00);
		i_host.pw(`PW_BASE_LOW, PW);
		repeat (3) @(negedge clk);
		chk("oem mode", 16'h1, 16'(oem));
		$display("test lock done");
	endtask
	task automatic t_cfg5();
		pin_mode = 1'b1;
		fault = 1'b1;
		wrs(`OEM_CFG_FIVE_ADDR, 8'h01);
		chk("laser_shutdown_output on", 16'h1, 16'(lso));
		chk("fault high", 16'h1, 16'(tfo));
		chk("timeout on", 16'h1, 16'(tmo));
		rdc(`OEM_CFG_FIVE_ADDR, 8'h01);
		wrs(`OEM_CFG_FIVE_ADDR, 8'h9A);
		chk("laser_shutdown_output off", 16'h0, 16'(lso));
		chk("fault low", 16'h0, 16'(tfo));
		chk("multipart", 16'h1, 16'(mp));
		chk("timeout off", 16'h0, 16'(tmo));
		meas = 11'sd100;
		toff = -6'sd4;
		wrs(`OEM_CFG_FIVE_ADDR, 8'h20);
		chk("result offs", 16'd96, 16'(tres));
		chk("lut plain", 16'd100, 16'(lut));
		wrs(`OEM_CFG_FIVE_ADDR, 8'h40);
		chk("result plain", 16'd100, 16'(tres));
		chk("lut offs", 16'd96, 16'(lut));
		chk("multipart off", 16'h0, 16'(mp));
		chk("laser_shutdown_output again", 16'h1, 16'(lso));
		pin_mode = 1'b0;
		repeat (2) @(negedge clk);
		chk("laser_shutdown_output pin off", 16'h0, 16'(lso));
		fault = 1'b0;
		repeat (2) @(negedge clk);
		chk("fault idle", 16'h0, 16'(tfo));
		$display("test cfg5 done");
	endtask
	task automatic t_cfg6();
		logic [2:0] exp_reg[4] = '{3'd0, 3'd5, 3'd2, 3'd0};
		rxp = 12'h5FF;
		for (int m = 0; m < 4; m++) begin
			wrs(`OEM_CFG_SIX_ADDR, {m[0], 2'(m), 5'h05});
			chk("lin mode", 16'(m), 16'(lin));
			chk("by temp", 16'(m == 0), 16'(cbt));
			chk("region", 16'(exp_reg[m]), 16'(reg_n));
			chk("scratch", 16'(m == 2), 16'(sxe));
			chk("a0 nack", 16'(m % 2), 16'(a0n));
			rdc(`OEM_CFG_SIX_ADDR, {m[0], 2'(m), 5'h05});
		end
		$display("test cfg6 done");
	endtask
	task automatic t_debounce();
		tx_off = 1'b1;
		repeat (2) @(negedge clk);
		chk("sync lag", 16'h0, 16'(txq));
		@(negedge clk);
		chk("sync pass", 16'h1, 16'(txq));
		wrs(`OEM_CFG_SIX_ADDR, 8'h10);
		tx_off = 1'b0;
		repeat (10) @(negedge clk);
		tx_off = 1'b1;
		repeat (30) @(negedge clk);
		chk("glitch kept", 16'h1, 16'(txq));
		tx_off = 1'b0;
		repeat (30) @(negedge clk);
		chk("long low", 16'h0, 16'(txq));
		$display("test debounce done");
	endtask
	task automatic t_pwloc();
		wrs(`OEM_CFG_FIVE_ADDR, 8'h04);
		chk("moved lock", 16'h0, 16'(oem));
		i_host.pw(`PW_BASE_HIGH, PW);
		repeat (3) @(negedge clk);
		chk("moved open", 16'h1, 16'(oem));
		$display("test pwloc done");
	endtask
	// ====================
	// Clock, reset, sequence and watchdog
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		{resetn, pin_mode, fault, tx_off, meas, toff, rxp} = '0;
		for (int i = 0; i < 7; i++) delims[i] = 12'(256 * (i + 1));
		repeat (20) @(negedge clk);
		resetn = 1'b1;
		t_lock();
		t_cfg5();
		t_cfg6();
		t_debounce();
		t_pwloc();
		results();
	end
	initial begin
		#200us;
		errors++;
		results();
	end
endmodule
